// *** srtc_consts.svh ***
// Constants for the serial timekeeper and its three-wire host
`ifndef SRTC_CONSTS_SVH
`define SRTC_CONSTS_SVH

// ============================================================
// Command byte layout
`define SRTC_CMD_START_BIT   7
`define SRTC_CMD_RAM_BIT     6
`define SRTC_CMD_ADDR_HI     5
`define SRTC_CMD_ADDR_LO     1
`define SRTC_CMD_READ_BIT    0
`define SRTC_BURST_ADDR      5'h1F

// ============================================================
// Register spaces
`define SRTC_CLK_REGS        5'h08
`define SRTC_CHG_ADDR        5'h08
`define SRTC_RAM_BYTES       5'h1F
`define SRTC_IDX_SEC         3'h0
`define SRTC_IDX_MIN         3'h1
`define SRTC_IDX_HR          3'h2
`define SRTC_IDX_DATE        3'h3
`define SRTC_IDX_MON         3'h4
`define SRTC_IDX_DAY         3'h5
`define SRTC_IDX_YEAR        3'h6
`define SRTC_IDX_CTRL        3'h7
`define SRTC_LAST_BIT        3'h7

// ============================================================
// Field positions and values
`define SRTC_HALT_BIT        7
`define SRTC_HR_12_BIT       7
`define SRTC_HR_PM_BIT       5
`define SRTC_WP_BIT          7
`define SRTC_SEC_MAX         7'h59
`define SRTC_MIN_MAX         8'h59
`define SRTC_HR24_MAX        6'h23
`define SRTC_HR12_MAX        5'h12
`define SRTC_HR12_PRE        5'h11
`define SRTC_HR12_MIN        5'h01
`define SRTC_DAY_MAX         8'h07
`define SRTC_MON_MAX         8'h12
`define SRTC_YEAR_MAX        8'h99
`define SRTC_FIRST           8'h01
`define SRTC_FEB             8'h02
`define SRTC_APR             8'h04
`define SRTC_JUN             8'h06
`define SRTC_SEP             8'h09
`define SRTC_NOV             8'h11
`define SRTC_DAYS_LEAP       8'h29
`define SRTC_DAYS_FEB        8'h28
`define SRTC_DAYS_30         8'h30
`define SRTC_DAYS_31         8'h31
`define SRTC_CHG_UNLOCK      4'hA
`define SRTC_DIODE_ONE       2'h1
`define SRTC_DIODE_TWO       2'h2
`define SRTC_RES_NONE        2'h0

// ============================================================
// Reset values and oscillator ticks per second
`define SRTC_RST_SEC         8'h80
`define SRTC_RST_CTRL        8'h80
`define SRTC_RST_CHG         8'h00
`define SRTC_OSC_TICKS_PER_SEC 32768

// ============================================================
// Host register map and fields
`define SRTC_HOST_CTRL       4'h0
`define SRTC_HOST_STATUS     4'h4
`define SRTC_HOST_DIV        4'h8
`define SRTC_HC_START        8
`define SRTC_HC_READ         9
`define SRTC_HC_KEEP         10
`define SRTC_HC_END          11
`define SRTC_HOST_DIV_RST    8'h08

`endif

// *** srtc_pkg.sv ***
// Types shared by both ends of the three-wire timekeeper link
package srtc_pkg;

  typedef logic [7:0][7:0]  srtc_clk_t;
  typedef logic [30:0][7:0] srtc_ram_t;

  typedef struct packed {
    logic        ce_q;
    logic        sclk_q;
    logic [2:0]  bitcnt;
    logic        have_cmd;
    logic        done;
    logic [7:0]  cmd;
    logic [7:0]  shreg;
    logic [4:0]  idx;
    logic        burst;
    logic        dout;
    logic        doe;
    srtc_clk_t   tr;
    srtc_clk_t   shadow;
    srtc_clk_t   wbuf;
    logic [7:0]  wmask;
    srtc_ram_t   ram;
    logic [7:0]  chg;
    logic        chg_on;
    logic [14:0] subsec;
  } srtc_dev_s;

  typedef enum logic [2:0] {
    SRTC_H_IDLE  = 3'b000,
    SRTC_H_CEUP  = 3'b001,
    SRTC_H_LOW   = 3'b010,
    SRTC_H_HIGH  = 3'b011,
    SRTC_H_CEDN  = 3'b100
  } srtc_host_e;

  typedef struct packed {
    srtc_host_e  st;
    logic        ce;
    logic        sclk;
    logic        io_o;
    logic        io_oe;
    logic [7:0]  cnt;
    logic [2:0]  bitn;
    logic [7:0]  txb;
    logic [7:0]  rxb;
    logic        rd;
    logic        keep;
    logic [7:0]  div;
    logic [31:0] hrdata;
    logic        ap_valid;
    logic        ap_wr;
    logic [3:0]  ap_addr;
  } srtc_host_s;

endpackage : srtc_pkg

// *** srtc_link_if.sv ***
// Three-wire link between host and timekeeper
`timescale 1ns/10ps
interface srtc_link_if;
  logic ce;
  logic sclk;
  logic io_dev_o;
  logic io_dev_oe;
  logic io_host_o;
  logic io_host_oe;
  logic io_line;

  // Weak pulldown on the data line when nobody drives it
  assign io_line = io_dev_oe ? io_dev_o : (io_host_oe ? io_host_o : 1'b0);

  modport dev  (input ce, input sclk, input io_line, output io_dev_o, output io_dev_oe);
  modport host (output ce, output sclk, output io_host_o, output io_host_oe, input io_line);
endinterface : srtc_link_if

// *** srtc_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module srtc_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } srtc_sync_s;

  srtc_sync_s s_ff;
  srtc_sync_s nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = d;
    nxt_s.stab = s_ff.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.stab;
endmodule : srtc_sync

// *** srtc_dev.sv ***
// Timekeeper end: serial slave, clock/calendar, scratch RAM, charger setup
`timescale 1ns/10ps
`include "srtc_consts.svh"

// Function
// (R1) Command LSB first; bit7 zero blocks writes
// (R2) Bit6 space, bits1-5 address, bit0 read
// (R3) Enable low ends transfer, releases data
// (R4) Host: clock low at enable rise
// (R5) Write byte sampled on rising edges
// (R6) Read bits driven on falling edges
// (R7) Read retransmits while clocks continue
// (R8) Release data line on each rising edge
// (R9) Address 31 is burst from address 0
// (R10) No storage clock 9-31, RAM 31
// (R11) Clock burst needs eight bytes; RAM per-byte
// (R12) Time registers hold BCD values
// (R13) Day of week increments at midnight
// (R14) Snapshot time on enable rise for reads
// (R15) Seconds write resets chain; commit at fall
// (R16) Host: finish time writes within second
// (R17) Hours 12/24 mode and afternoon flag
// (R18) Seconds bit7 halts the oscillator
// (R19) Control bit7 write lock, rest zero
// (R20) Locked clock burst writes nothing
// (R21) Charger needs unlock pattern and diode select
// (R22) Resistor select, none disables charger
module srtc_dev
  import srtc_pkg::*;
#(
  parameter int OSC_TICKS = `SRTC_OSC_TICKS_PER_SEC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clk_en,
  input  wire logic       osc_tick,
  srtc_link_if.dev        link,
  output logic            oscillator_running,
  output logic            charger_enable,
  output logic [1:0]      diode_count_select,
  output logic [1:0]      charge_resistor_choice
);

  // ============================================================
  // Calendar helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction : bcd_inc

  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic [4:0] lsum;
    lsum = {3'h0, yr[4], 1'b0} + {1'b0, yr[3:0]};
    case (mon)
      `SRTC_FEB: month_days = (lsum[1:0] == 2'h0) ? `SRTC_DAYS_LEAP : `SRTC_DAYS_FEB;
      `SRTC_APR, `SRTC_JUN, `SRTC_SEP, `SRTC_NOV: month_days = `SRTC_DAYS_30;
      default:   month_days = `SRTC_DAYS_31;
    endcase
  endfunction : month_days

  function automatic srtc_clk_t tick_second(input srtc_clk_t r);
    srtc_clk_t  t;
    logic       midnight;
    logic [4:0] h12;
    t        = r;
    midnight = 1'b0;
    h12      = r[`SRTC_IDX_HR][4:0];
    if (r[`SRTC_IDX_SEC][6:0] != `SRTC_SEC_MAX) begin
      t[`SRTC_IDX_SEC] = bcd_inc(r[`SRTC_IDX_SEC]); // R12
    end else begin
      t[`SRTC_IDX_SEC][6:0] = 7'h00;
      if (r[`SRTC_IDX_MIN] != `SRTC_MIN_MAX) begin
        t[`SRTC_IDX_MIN] = bcd_inc(r[`SRTC_IDX_MIN]);
      end else begin
        t[`SRTC_IDX_MIN] = 8'h00;
        if (r[`SRTC_IDX_HR][`SRTC_HR_12_BIT]) begin // R17
          if (h12 == `SRTC_HR12_MAX) begin
            t[`SRTC_IDX_HR][4:0] = `SRTC_HR12_MIN;
          end else begin
            t[`SRTC_IDX_HR][4:0] = 5'(bcd_inc({3'h0, h12}));
          end
          if (h12 == `SRTC_HR12_PRE) begin
            t[`SRTC_IDX_HR][`SRTC_HR_PM_BIT] = ~r[`SRTC_IDX_HR][`SRTC_HR_PM_BIT];
            midnight = r[`SRTC_IDX_HR][`SRTC_HR_PM_BIT];
          end
        end else if (r[`SRTC_IDX_HR][5:0] == `SRTC_HR24_MAX) begin
          t[`SRTC_IDX_HR][5:0] = 6'h00;
          midnight             = 1'b1;
        end else begin
          t[`SRTC_IDX_HR][5:0] = 6'(bcd_inc({2'h0, r[`SRTC_IDX_HR][5:0]}));
        end
      end
    end
    if (midnight) begin
      t[`SRTC_IDX_DAY] = (r[`SRTC_IDX_DAY] == `SRTC_DAY_MAX) ? `SRTC_FIRST
                                                             : bcd_inc(r[`SRTC_IDX_DAY]); // R13
      if (r[`SRTC_IDX_DATE] != month_days(r[`SRTC_IDX_MON], r[`SRTC_IDX_YEAR])) begin
        t[`SRTC_IDX_DATE] = bcd_inc(r[`SRTC_IDX_DATE]);
      end else begin
        t[`SRTC_IDX_DATE] = `SRTC_FIRST;
        if (r[`SRTC_IDX_MON] != `SRTC_MON_MAX) begin
          t[`SRTC_IDX_MON] = bcd_inc(r[`SRTC_IDX_MON]);
        end else begin
          t[`SRTC_IDX_MON]  = `SRTC_FIRST;
          t[`SRTC_IDX_YEAR] = (r[`SRTC_IDX_YEAR] == `SRTC_YEAR_MAX) ? 8'h00
                                                                    : bcd_inc(r[`SRTC_IDX_YEAR]);
        end
      end
    end
    tick_second = t;
  endfunction : tick_second

  // ============================================================
  // Pin synchronisers
  logic [2:0] pins_s;
  logic       ce_s;
  logic       sclk_s;
  logic       io_s;

  srtc_sync #(.W(3)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       ({link.ce, link.sclk, link.io_line}),
    .q       (pins_s)
  );
  assign {ce_s, sclk_s, io_s} = pins_s;

  // ============================================================
  // State
  srtc_dev_s s_ff;
  srtc_dev_s nxt_s;

  logic       ce_rise;
  logic       ce_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       is_ram;
  logic       is_read;
  logic       wr_ok;
  logic       locked;
  logic [7:0] c;
  logic [7:0] d;
  logic [7:0] rd_byte;
  logic [4:0] last_idx;

  always_comb begin
    nxt_s     = s_ff;
    ce_rise   = ce_s & ~s_ff.ce_q;
    ce_fall   = ~ce_s & s_ff.ce_q;
    sclk_rise = sclk_s & ~s_ff.sclk_q;
    sclk_fall = ~sclk_s & s_ff.sclk_q;
    is_ram    = s_ff.cmd[`SRTC_CMD_RAM_BIT];                       // R2
    is_read   = s_ff.cmd[`SRTC_CMD_READ_BIT];
    wr_ok     = s_ff.cmd[`SRTC_CMD_START_BIT] & ~is_read;          // R1
    locked    = s_ff.tr[`SRTC_IDX_CTRL][`SRTC_WP_BIT];
    last_idx  = is_ram ? 5'(`SRTC_RAM_BYTES - 5'h01) : 5'(`SRTC_CLK_REGS - 5'h01);
    c         = s_ff.cmd;
    d         = s_ff.shreg;
    nxt_s.ce_q   = ce_s;
    nxt_s.sclk_q = sclk_s;

    // Read source: snapshot for time, live for control, charger and RAM
    rd_byte = 8'h00;
    if (is_ram) begin
      if (s_ff.idx < `SRTC_RAM_BYTES) rd_byte = s_ff.ram[s_ff.idx];  // R10
    end else if (s_ff.idx == 5'(`SRTC_IDX_CTRL)) begin
      rd_byte = {locked, 7'h00};                                    // R19
    end else if (s_ff.idx < `SRTC_CLK_REGS) begin
      rd_byte = s_ff.shadow[s_ff.idx[2:0]];                         // R14
    end else if (s_ff.idx == `SRTC_CHG_ADDR) begin
      rd_byte = s_ff.chg;
    end

    // Timekeeping runs unless halted
    if (osc_tick && !s_ff.tr[`SRTC_IDX_SEC][`SRTC_HALT_BIT]) begin // R18
      if (s_ff.subsec == 15'(OSC_TICKS - 1)) begin
        nxt_s.subsec = 15'h0000;
        nxt_s.tr     = tick_second(s_ff.tr);
      end else begin
        nxt_s.subsec = 15'(s_ff.subsec + 15'h0001);
      end
    end

    if (!ce_s) begin
      nxt_s.doe = 1'b0;                                             // R3
    end

    if (ce_rise) begin
      nxt_s.shadow   = s_ff.tr;                                     // R14
      nxt_s.bitcnt   = 3'h0;
      nxt_s.have_cmd = 1'b0;
      nxt_s.done     = 1'b0;
      nxt_s.wmask    = 8'h00;
      nxt_s.cmd      = 8'h00;
    end else if (ce_fall && s_ff.have_cmd && wr_ok && !is_ram) begin
      // Time data moves over only when the enable drops
      if (s_ff.burst) begin
        if (s_ff.wmask == 8'hFF && !locked) begin                  // R11 R20
          nxt_s.tr     = s_ff.wbuf;
          nxt_s.tr[`SRTC_IDX_CTRL][6:0] = 7'h00;                    // R19
          nxt_s.subsec = 15'h0000;                                  // R15
        end
      end else begin
        for (int i = 0; i < 8; i++) begin
          if (s_ff.wmask[i] && (!locked || i == int'(`SRTC_IDX_CTRL))) begin // R19
            nxt_s.tr[i] = s_ff.wbuf[i];                             // R15
            if (i == int'(`SRTC_IDX_SEC)) nxt_s.subsec = 15'h0000;  // R15
          end
        end
        nxt_s.tr[`SRTC_IDX_CTRL][6:0] = 7'h00;
      end
    end else if (ce_s && sclk_rise) begin
      nxt_s.doe = 1'b0;                                             // R8
      if (!s_ff.have_cmd) begin
        c[s_ff.bitcnt] = io_s;                                      // R1
        nxt_s.cmd      = c;
        nxt_s.bitcnt   = 3'(s_ff.bitcnt + 3'h1);
        if (s_ff.bitcnt == `SRTC_LAST_BIT) begin
          nxt_s.have_cmd = 1'b1;
          nxt_s.burst    = (c[`SRTC_CMD_ADDR_HI:`SRTC_CMD_ADDR_LO] == `SRTC_BURST_ADDR); // R9
          nxt_s.idx      = nxt_s.burst ? 5'h00 : c[`SRTC_CMD_ADDR_HI:`SRTC_CMD_ADDR_LO];
        end
      end else if (wr_ok && !s_ff.done) begin
        d[s_ff.bitcnt] = io_s;                                      // R5
        nxt_s.shreg    = d;
        nxt_s.bitcnt   = 3'(s_ff.bitcnt + 3'h1);
        if (s_ff.bitcnt == `SRTC_LAST_BIT) begin
          if (is_ram) begin
            if (s_ff.idx < `SRTC_RAM_BYTES && !locked) begin
              nxt_s.ram[s_ff.idx] = d;                              // R11
            end
          end else if (s_ff.idx < `SRTC_CLK_REGS) begin
            nxt_s.wbuf[s_ff.idx[2:0]]  = d;
            nxt_s.wmask[s_ff.idx[2:0]] = 1'b1;
          end else if (s_ff.idx == `SRTC_CHG_ADDR && !s_ff.burst && !locked) begin
            nxt_s.chg = d;                                          // R20
          end
          // Single writes ignore further clocks; bursts stop at the space end
          nxt_s.done = !s_ff.burst || (s_ff.idx == last_idx);       // R5 R10
          nxt_s.idx  = 5'(s_ff.idx + 5'h01);
        end
      end
    end else if (ce_s && sclk_fall && s_ff.have_cmd && is_read) begin
      nxt_s.dout   = rd_byte[s_ff.bitcnt];                          // R6
      nxt_s.doe    = 1'b1;
      nxt_s.bitcnt = 3'(s_ff.bitcnt + 3'h1);
      if (s_ff.bitcnt == `SRTC_LAST_BIT && s_ff.burst) begin
        nxt_s.idx = (s_ff.idx == last_idx) ? 5'h00 : 5'(s_ff.idx + 5'h01); // R7 R9
      end
    end

    nxt_s.chg_on = (nxt_s.chg[7:4] == `SRTC_CHG_UNLOCK) &&          // R21
                   (nxt_s.chg[3:2] == `SRTC_DIODE_ONE || nxt_s.chg[3:2] == `SRTC_DIODE_TWO) &&
                   (nxt_s.chg[1:0] != `SRTC_RES_NONE);               // R22
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff                     <= '0;
      s_ff.tr[`SRTC_IDX_SEC]   <= `SRTC_RST_SEC;
      s_ff.tr[`SRTC_IDX_DATE]  <= `SRTC_FIRST;
      s_ff.tr[`SRTC_IDX_MON]   <= `SRTC_FIRST;
      s_ff.tr[`SRTC_IDX_DAY]   <= `SRTC_FIRST;
      s_ff.tr[`SRTC_IDX_CTRL]  <= `SRTC_RST_CTRL;
      s_ff.chg                 <= `SRTC_RST_CHG;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  // ============================================================
  // Outputs
  assign link.io_dev_o          = s_ff.dout;
  assign link.io_dev_oe         = s_ff.doe;                         // R3 R8
  assign oscillator_running     = ~s_ff.tr[`SRTC_IDX_SEC][`SRTC_HALT_BIT];
  assign charger_enable         = s_ff.chg_on;
  assign diode_count_select     = s_ff.chg[3:2];
  assign charge_resistor_choice = s_ff.chg[1:0];
endmodule : srtc_dev

// *** srtc_host.sv ***
// Host end: AHB-Lite controlled three-wire master
`timescale 1ns/10ps
`include "srtc_consts.svh"
module srtc_host
  import srtc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  srtc_link_if.host        link
);
  logic io_s;

  srtc_sync #(.W(1)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d       (link.io_line),
    .q       (io_s)
  );

  srtc_host_s s_ff;
  srtc_host_s nxt_s;
  logic       wr_ctrl;

  // ============================================================
  // Bus slave and link sequencer
  always_comb begin
    nxt_s   = s_ff;
    wr_ctrl = s_ff.ap_valid && s_ff.ap_wr && s_ff.ap_addr == `SRTC_HOST_CTRL;
    nxt_s.ap_valid = hsel && hready && htrans[1];
    nxt_s.ap_wr    = hwrite;
    nxt_s.ap_addr  = haddr[3:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[3:0])
        `SRTC_HOST_STATUS: nxt_s.hrdata = {16'h0000, s_ff.rxb, 6'h00, s_ff.ce,
                                           s_ff.st != SRTC_H_IDLE};
        `SRTC_HOST_DIV:    nxt_s.hrdata = {24'h000000, s_ff.div};
        default:           nxt_s.hrdata = 32'h00000000;
      endcase
    end
    if (s_ff.ap_valid && s_ff.ap_wr && s_ff.ap_addr == `SRTC_HOST_DIV) begin
      nxt_s.div = hwdata[7:0];
    end
    if (s_ff.cnt != 8'h00) nxt_s.cnt = 8'(s_ff.cnt - 8'h01);

    case (s_ff.st)
      SRTC_H_IDLE: begin
        if (wr_ctrl && hwdata[`SRTC_HC_START]) begin
          nxt_s.txb  = hwdata[7:0];
          nxt_s.rd   = hwdata[`SRTC_HC_READ];
          nxt_s.keep = hwdata[`SRTC_HC_KEEP];
          nxt_s.bitn = 3'h0;
          nxt_s.cnt  = s_ff.div;
          if (!s_ff.ce) begin
            nxt_s.ce = 1'b1;                                        // R4
            nxt_s.st = SRTC_H_CEUP;
          end else begin
            nxt_s.io_o  = hwdata[0];
            nxt_s.io_oe = ~hwdata[`SRTC_HC_READ];
            nxt_s.st    = SRTC_H_LOW;
          end
        end else if (wr_ctrl && hwdata[`SRTC_HC_END] && s_ff.ce) begin
          nxt_s.cnt = s_ff.div;
          nxt_s.st  = SRTC_H_CEDN;
        end
      end
      SRTC_H_CEUP: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.io_o  = s_ff.txb[0];
          nxt_s.io_oe = ~s_ff.rd;
          nxt_s.cnt   = s_ff.div;
          nxt_s.st    = SRTC_H_LOW;
        end
      end
      SRTC_H_LOW: begin
        if (s_ff.cnt == 8'h00) begin
          if (s_ff.rd) nxt_s.rxb[s_ff.bitn] = io_s;                 // R6
          nxt_s.sclk = 1'b1;                                        // R5
          nxt_s.cnt  = s_ff.div;
          nxt_s.st   = SRTC_H_HIGH;
        end
      end
      SRTC_H_HIGH: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.sclk = 1'b0;
          nxt_s.cnt  = s_ff.div;
          nxt_s.bitn = 3'(s_ff.bitn + 3'h1);
          if (s_ff.bitn == `SRTC_LAST_BIT) begin
            nxt_s.io_oe = 1'b0;
            nxt_s.st    = s_ff.keep ? SRTC_H_IDLE : SRTC_H_CEDN;
          end else begin
            nxt_s.io_o = s_ff.txb[3'(s_ff.bitn + 3'h1)];
            nxt_s.st   = SRTC_H_LOW;
          end
        end
      end
      SRTC_H_CEDN: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.ce = 1'b0;                                          // R3
          nxt_s.st = SRTC_H_IDLE;
        end
      end
      default: nxt_s.st = SRTC_H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff     <= '0;
      s_ff.st  <= SRTC_H_IDLE;
      s_ff.div <= `SRTC_HOST_DIV_RST;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = s_ff.hrdata;
  assign link.ce         = s_ff.ce;
  assign link.sclk       = s_ff.sclk;
  assign link.io_host_o  = s_ff.io_o;
  assign link.io_host_oe = s_ff.io_oe;
endmodule : srtc_host

// *** srtc_link_assertions.sv ***
// Protocol checks on the three-wire link between host and timekeeper
`timescale 1ns/10ps
module srtc_link_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic io_dev_o,
  input wire logic io_dev_oe,
  input wire logic io_host_o,
  input wire logic io_host_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ============================================================
  // Assertions
  ce_rise_quiet_a: assert property ($rose(ce) |-> !sclk [*8])
    else $error("shift clock not low after enable rise");
  idle_sclk_a: assert property (!ce |-> !sclk)
    else $error("shift clock moves outside a frame");
  ce_release_a: assert property (!ce [*6] |-> !io_dev_oe)
    else $error("device drives data with enable low");
  rise_release_a: assert property ($rose(sclk) |-> ##[1:6] !io_dev_oe)
    else $error("device holds data past a rising shift edge");
  fall_drive_a: assert property ($rose(io_dev_oe) |-> !sclk && ce)
    else $error("device starts driving outside low clock phase");
  no_fight_a: assert property (!(io_dev_oe && io_host_oe))
    else $error("both ends drive the data line");
  dev_hold_a: assert property (io_dev_oe && $past(io_dev_oe) |-> $stable(io_dev_o))
    else $error("device data changes while driven");
  host_setup_a: assert property ($rose(sclk) && io_host_oe |-> $stable(io_host_o))
    else $error("host data changes at the sampling edge");
  // Main scenarios: read bits, frame end, written bits
  cover property ($rose(io_dev_oe));
  cover property ($fell(ce));
  cover property ($rose(sclk) && io_host_oe);
endmodule : srtc_link_assertions

// *** serial_rtc_with_scratch_ram_test.sv ***
// Self-checking bench: AHB host driving the timekeeper over the link
`timescale 1ns/10ps
module serial_rtc_with_scratch_ram_test;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        osc_tick = 1'b0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        osc_run;
  logic        chg_en;
  logic [1:0]  diode;
  logic [1:0]  res;
  logic [7:0]  rb;
  int          failures = 0;
  int          comparisons = 0;
  srtc_link_if lk ();
  srtc_dev #(.OSC_TICKS(4)) srtc_dev_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .osc_tick(osc_tick), .link(lk), .oscillator_running(osc_run),
    .charger_enable(chg_en), .diode_count_select(diode), .charge_resistor_choice(res));
  srtc_host srtc_host_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .link(lk));
  srtc_link_assertions srtc_link_assertions_i (.hclk(hclk), .hresetn(hresetn), .ce(lk.ce),
    .sclk(lk.sclk), .io_dev_o(lk.io_dev_o), .io_dev_oe(lk.io_dev_oe),
    .io_host_o(lk.io_host_o), .io_host_oe(lk.io_host_oe));
  initial forever #2 hclk = ~hclk;
  always @(posedge hclk) osc_tick <= ~osc_tick;
  // ============================================================
  // Bus and link helpers
  task end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("mismatch hready expected 1 seen %b", hreadyout);
      end_sim;
    end
  endtask : rdy
  task ahb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {28'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask : ahb
  // Poll busy; a byte takes about 160 cycles at the reset divider, so the bound is generous
  task idle(output logic [31:0] s);
    int n;
    n = 0;
    @(posedge hclk);
    do begin
      ahb(1'b0, 4'h4, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 3000);
    if (s[0] !== 1'b0) begin
      failures++;
      $display("mismatch busy expected 0 seen %b", s[0]);
      end_sim;
    end
  endtask : idle
  task xfer(input logic [7:0] b, input logic rd, input logic keep, output logic [7:0] got);
    logic [31:0] s;
    idle(s);
    ahb(1'b1, 4'h0, {21'h0, keep, rd, 1'b1, b}, s);
    idle(s);
    got = s[15:8];
  endtask : xfer
  task wr(input logic [7:0] cmd, input logic [7:0] d);
    xfer(cmd, 1'b0, 1'b1, rb);
    xfer(d, 1'b0, 1'b0, rb);
  endtask : wr
  task rd(input logic [7:0] cmd, input string name, input logic [7:0] exp);
    xfer(cmd, 1'b0, 1'b1, rb);
    xfer(8'h00, 1'b1, 1'b0, rb);
    chk(name, exp, rb);
  endtask : rd
  // ============================================================
  // Scenarios
  task t_lock;
    chk("charger_enable", 8'h00, {7'h0, chg_en});
    chk("oscillator_running", 8'h00, {7'h0, osc_run});
    rd(8'h8F, "control", 8'h80);
    wr(8'hC0, 8'h55);
    rd(8'hC1, "ram0 locked", 8'h00);
    wr(8'h8E, 8'h7F);
    rd(8'h8F, "control cleared", 8'h00);
    $display("test lock done");
  endtask : t_lock
  task t_ram;
    wr(8'hC0, 8'hA5);
    wr(8'hC2, 8'h5A);
    wr(8'h40, 8'h3C);
    rd(8'hC1, "ram0", 8'hA5);
    xfer(8'hFF, 1'b0, 1'b1, rb);
    xfer(8'h00, 1'b1, 1'b1, rb);
    chk("burst byte0", 8'hA5, rb);
    xfer(8'h00, 1'b1, 1'b0, rb);
    chk("burst byte1", 8'h5A, rb);
    $display("test ram done");
  endtask : t_ram
  task t_chg;
    logic [7:0] v [5] = '{8'hA5, 8'hA4, 8'hAD, 8'hAA, 8'h55};
    logic       e [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr(8'h90, v[i]);
      chk("charger_enable", {7'h0, e[i]}, {7'h0, chg_en});
      chk("select", {4'h0, v[i][3:0]}, {4'h0, diode, res});
    end
    $display("test charger done");
  endtask : t_chg
  task t_time;
    wr(8'h84, 8'hB2);
    rd(8'h85, "hours", 8'hB2);
    rd(8'h93, "clock addr 9", 8'h00);
    wr(8'h80, 8'h00);
    // Time commit lands only after the enable drop has crossed the pin synchroniser
    repeat (4) @(posedge hclk);
    chk("oscillator_running", 8'h01, {7'h0, osc_run});
    $display("test time done");
  endtask : t_time
  task t_burst;
    logic [7:0]  v [8] = '{8'h80, 8'h15, 8'h08, 8'h21, 8'h03, 8'h02, 8'h24, 8'h00};
    logic [31:0] s;
    xfer(8'hBE, 1'b0, 1'b1, rb);
    for (int i = 0; i < 8; i++) xfer(v[i], 1'b0, i < 7, rb);
    rd(8'h83, "burst minutes", 8'h15);
    rd(8'h8D, "burst year", 8'h24);
    xfer(8'hBE, 1'b0, 1'b1, rb);
    xfer(8'h00, 1'b0, 1'b0, rb);
    rd(8'h81, "partial burst seconds", 8'h80);
    xfer(8'hFE, 1'b0, 1'b1, rb);
    xfer(8'h11, 1'b0, 1'b1, rb);
    xfer(8'h22, 1'b0, 1'b0, rb);
    rd(8'hC3, "ram burst byte1", 8'h22);
    ahb(1'b0, 4'h8, 32'h0, s);
    chk("divider", 8'h08, s[7:0]);
    $display("test burst done");
  endtask : t_burst
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_lock;
    t_ram;
    t_chg;
    t_time;
    t_burst;
    end_sim;
  end
endmodule : serial_rtc_with_scratch_ram_test
